// ==== pkg/svc_pkg.sv ====
// svc_pkg: register map, field layout and timing constants for the speaker volume control bank
// assumes a plain register port with page select, address and byte data from the host codec core
package svc_pkg;
   localparam logic [7:0] ADDR_ROUTE = 8'h23;
   localparam logic [7:0] ADDR_LVOL = 8'h26;
   localparam logic [7:0] ADDR_RVOL = 8'h27;
   localparam logic [7:0] ADDR_STEP = 8'h3f;
   localparam logic PAGE_TIMING = 1'h0;
   localparam logic PAGE_VOLUME = 1'h1;
   localparam int BIT_ROUTE_L = 6;
   localparam int BIT_ROUTE_R = 2;
   localparam int BIT_AMP = 7;
   localparam int CODE_W = 7;
   localparam logic [6:0] CODE_MUTE_FIRST = 7'h75;
   localparam logic [6:0] CODE_DEEPEST = 7'h75;
   localparam logic [6:0] CODE_RESET = 7'h7f;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_VOL = 8'h7f;
   // step interval per timing code, in microseconds; code 3 stops stepping
   localparam int STEP_US_0 = 61;
   localparam int STEP_US_1 = 122;
   localparam int STEP_US_2 = 244;
   localparam int CLK_MHZ = 50;
   localparam int STEP_CYC_0 = STEP_US_0 * CLK_MHZ;
   localparam int STEP_CYC_1 = STEP_US_1 * CLK_MHZ;
   localparam int STEP_CYC_2 = STEP_US_2 * CLK_MHZ;
   localparam logic [1:0] STEP_OFF = 2'h3;

   typedef struct packed {
      logic routed;
      logic amp_conn;
      logic mute;
      logic [6:0] code;
   } svc_chan_t;
endpackage : svc_pkg

// ==== src/svc_bank.sv ====
// svc_bank: speaker volume register bank with soft-stepped applied codes per channel
// assumes host writes are synchronous to sys_clk; analog stage consumes the applied outputs
`timescale 1ns/1ps
`default_nettype none

module svc_bank #(
   parameter int STEP_CYC_0 = svc_pkg::STEP_CYC_0,
   parameter int STEP_CYC_1 = svc_pkg::STEP_CYC_1,
   parameter int STEP_CYC_2 = svc_pkg::STEP_CYC_2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_page,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   output svc_pkg::svc_chan_t left_chan,
   output svc_pkg::svc_chan_t right_chan,
   output logic ramp_busy
);
   logic [7:0] route_r, lvol_r, rvol_r, step_r;
   logic [6:0] lcur_r, rcur_r;
   logic [15:0] tick_cnt_r;
   logic tick;
   logic [15:0] tick_limit;

   // page and address match shared by read and write decode
   function automatic logic sel(input logic pg, input logic [7:0] ad, input logic wp, input logic [7:0] wa);
      sel = (pg == wp) && (ad == wa);
   endfunction : sel

   // register writes; reserved bits are kept so a read shows what was written
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         route_r <= svc_pkg::RESET_BYTE;
         lvol_r <= svc_pkg::RESET_VOL;
         rvol_r <= svc_pkg::RESET_VOL;
         step_r <= svc_pkg::RESET_BYTE;
      end else if (reg_wr) begin
         if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_ROUTE)) route_r <= reg_wdata;
         if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_LVOL)) lvol_r <= reg_wdata;
         if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_RVOL)) rvol_r <= reg_wdata;
         if (sel(reg_page, reg_addr, svc_pkg::PAGE_TIMING, svc_pkg::ADDR_STEP)) step_r <= reg_wdata;
      end
   end

   // read mux; unmapped addresses read zero and drop reg_hit
   always_comb begin
      reg_rdata = 8'h00;
      reg_hit = 1'b1;
      if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_ROUTE)) reg_rdata = route_r;
      else if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_LVOL)) reg_rdata = lvol_r;
      else if (sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_RVOL)) reg_rdata = rvol_r;
      else if (sel(reg_page, reg_addr, svc_pkg::PAGE_TIMING, svc_pkg::ADDR_STEP)) reg_rdata = step_r;
      else reg_hit = 1'b0;
   end

   // interval select; timing code 3 disables stepping and applies targets at once
   always_comb begin
      unique case (step_r[1:0])
         2'h0: tick_limit = 16'(STEP_CYC_0 - 1);
         2'h1: tick_limit = 16'(STEP_CYC_1 - 1);
         2'h2: tick_limit = 16'(STEP_CYC_2 - 1);
         2'h3: tick_limit = 16'h0000;
      endcase
   end

   // free-running interval timer, restarted whenever the limit is reached
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) tick_cnt_r <= 16'h0000;
      else if (tick_cnt_r >= tick_limit) tick_cnt_r <= 16'h0000;
      else tick_cnt_r <= tick_cnt_r + 16'h0001;
   end
   assign tick = (tick_cnt_r >= tick_limit);

   // one code per tick toward target; the applied code only jumps more than one code when timing code 3 applies targets at once
   function automatic logic [6:0] step_to(input logic [6:0] cur, input logic [6:0] tgt);
      if (cur < tgt) step_to = cur + 7'h01;
      else if (cur > tgt) step_to = cur - 7'h01;
      else step_to = cur;
   endfunction : step_to

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lcur_r <= svc_pkg::CODE_RESET;
         rcur_r <= svc_pkg::CODE_RESET;
      end else if (step_r[1:0] == svc_pkg::STEP_OFF) begin
         lcur_r <= lvol_r[6:0];
         rcur_r <= rvol_r[6:0];
      end else if (tick) begin
         lcur_r <= step_to(lcur_r, lvol_r[6:0]);
         rcur_r <= step_to(rcur_r, rvol_r[6:0]);
      end
   end

   // codes 117 and up share the deepest step when amp connected, mute otherwise;
   // clamping to 117 rather than 116 keeps the -72.2 dB step of code 116 intact
   function automatic svc_pkg::svc_chan_t chan_out(input logic rt, input logic [7:0] vol, input logic [6:0] cur);
      chan_out.routed = rt;
      chan_out.amp_conn = vol[svc_pkg::BIT_AMP];
      chan_out.mute = !vol[svc_pkg::BIT_AMP] && (cur >= svc_pkg::CODE_MUTE_FIRST);
      chan_out.code = (vol[svc_pkg::BIT_AMP] && cur >= svc_pkg::CODE_MUTE_FIRST) ? svc_pkg::CODE_DEEPEST : cur;
   endfunction : chan_out

   // outputs registered so the analog stage sees clean levels
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         left_chan <= '0;
         right_chan <= '0;
         ramp_busy <= 1'b0;
      end else begin
         left_chan <= chan_out(route_r[svc_pkg::BIT_ROUTE_L], lvol_r, lcur_r);
         right_chan <= chan_out(route_r[svc_pkg::BIT_ROUTE_R], rvol_r, rcur_r);
         ramp_busy <= (lcur_r != lvol_r[6:0]) || (rcur_r != rvol_r[6:0]);
      end
   end

   step_one_a: assert property (@(posedge sys_clk) disable iff (rst)
      (lcur_r != $past(lcur_r)) |-> (lcur_r - $past(lcur_r) == 7'h01 || $past(lcur_r) - lcur_r == 7'h01
         || $past(step_r[1:0]) == svc_pkg::STEP_OFF)) else $error("left code jumped");
   step_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(lcur_r) == $past(lvol_r[6:0]) && $stable(lvol_r)) |-> $stable(lcur_r)) else $error("left ramp overshoot");
   mute_map_a: assert property (@(posedge sys_clk) disable iff (rst)
      (!lvol_r[svc_pkg::BIT_AMP] && lcur_r >= svc_pkg::CODE_MUTE_FIRST) |=> left_chan.mute) else $error("left not muted");
   deep_map_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rvol_r[svc_pkg::BIT_AMP] && rcur_r >= svc_pkg::CODE_MUTE_FIRST)
      |=> (right_chan.code == svc_pkg::CODE_DEEPEST && !right_chan.mute))
      else $error("right deepest wrong");
   route_left_a: assert property (@(posedge sys_clk) disable iff (rst)
      1'b1 |=> left_chan.routed == $past(route_r[svc_pkg::BIT_ROUTE_L])) else $error("left route wrong");
   route_right_a: assert property (@(posedge sys_clk) disable iff (rst)
      1'b1 |=> right_chan.routed == $past(route_r[svc_pkg::BIT_ROUTE_R])) else $error("right route wrong");

   // write strobes that hit one register; the link bit needs two edges to reach the output
   sequence lvol_write_s;
      reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_LVOL);
   endsequence
   sequence rvol_write_s;
      reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_RVOL);
   endsequence
   sequence route_write_s;
      reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_ROUTE);
   endsequence

   amp_left_a: assert property (@(posedge sys_clk) disable iff (rst)
      lvol_write_s |=> ##1 left_chan.amp_conn == $past(reg_wdata[svc_pkg::BIT_AMP], 2))
      else $error("left amp link wrong");
   amp_right_a: assert property (@(posedge sys_clk) disable iff (rst)
      rvol_write_s |=> ##1 right_chan.amp_conn == $past(reg_wdata[svc_pkg::BIT_AMP], 2))
      else $error("right amp link wrong");
   route_store_a: assert property (@(posedge sys_clk) disable iff (rst)
      route_write_s |=> route_r == $past(reg_wdata))
      else $error("routing not stored");

   // right ramp must obey the same single-code rule as the left
   step_right_a: assert property (@(posedge sys_clk) disable iff (rst)
      (rcur_r != $past(rcur_r)) |-> (rcur_r - $past(rcur_r) == 7'h01 || $past(rcur_r) - rcur_r == 7'h01
         || $past(step_r[1:0]) == svc_pkg::STEP_OFF)) else $error("right code jumped");

   // applied code only moves on an interval tick, so the pace follows the timing field
   step_pace_a: assert property (@(posedge sys_clk) disable iff (rst)
      (lcur_r != $past(lcur_r)) |-> $past(tick)) else $error("left moved off tick");

   // a tick below target must raise the code, never lower or hold it
   step_toward_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(tick) && $past(step_r[1:0]) != svc_pkg::STEP_OFF && $past(lcur_r) < $past(lvol_r[6:0]))
      |-> lcur_r == $past(lcur_r) + 7'h01) else $error("left ramp wrong way");

   // stepping off: the target is applied on the very next edge
   step_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(step_r[1:0]) == svc_pkg::STEP_OFF) |-> lcur_r == $past(lvol_r[6:0]))
      else $error("left target not applied");

   mute_right_a: assert property (@(posedge sys_clk) disable iff (rst)
      (!rvol_r[svc_pkg::BIT_AMP] && rcur_r >= svc_pkg::CODE_MUTE_FIRST) |=> right_chan.mute)
      else $error("right not muted");
   deep_left_a: assert property (@(posedge sys_clk) disable iff (rst)
      (lvol_r[svc_pkg::BIT_AMP] && lcur_r >= svc_pkg::CODE_MUTE_FIRST)
      |=> (left_chan.code == svc_pkg::CODE_DEEPEST && !left_chan.mute))
      else $error("left deepest wrong");

   // codes in the attenuating range pass straight through, never muted
   pass_left_a: assert property (@(posedge sys_clk) disable iff (rst)
      (lcur_r < svc_pkg::CODE_MUTE_FIRST) |=> (left_chan.code == $past(lcur_r) && !left_chan.mute))
      else $error("left code not passed");

   // busy must show while the applied code lags its target
   busy_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      (lcur_r != lvol_r[6:0]) |=> ramp_busy) else $error("busy missing");

   // writes to unmapped places leave every register alone
   refuse_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && !reg_hit) |=> ($stable(route_r) && $stable(lvol_r) && $stable(rvol_r) && $stable(step_r)))
      else $error("refused write landed");
   vol_right_a: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_RVOL)) |=> rvol_r == $past(reg_wdata))
      else $error("right volume not stored");
   timing_store_a: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_TIMING, svc_pkg::ADDR_STEP)) |=> step_r[1:0] == $past(reg_wdata[1:0]))
      else $error("timing not stored");
   left_code_a: assert property (@(posedge sys_clk) disable iff (rst)
      (reg_wr && sel(reg_page, reg_addr, svc_pkg::PAGE_VOLUME, svc_pkg::ADDR_LVOL)) |=> lvol_r[6:0] == $past(reg_wdata[6:0]))
      else $error("left code not stored");
endmodule : svc_bank

`default_nettype wire

// ==== verif/testbench.sv ====
// testbench: random and corner register traffic for the speaker volume bank
// assumes svc_pkg is compiled first; step intervals are shortened to 2/3/4 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t %h %h", $time, a, b); end end
module testbench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_page = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_hit;
   svc_pkg::svc_chan_t left_chan;
   svc_pkg::svc_chan_t right_chan;
   svc_pkg::svc_chan_t prev_l;
   logic ramp_busy;
   logic [1:0] tcode = 2'h3;
   logic [6:0] cur_l = 7'h7f;
   logic [6:0] corner [5] = '{7'h00, 7'h1b, 7'h74, 7'h75, 7'h7f};
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   int last_chg = 0;
   bit have_prev = 1'b0;
   svc_bank #(.STEP_CYC_0(2), .STEP_CYC_1(3), .STEP_CYC_2(4)) svc_bank_inst (.sys_clk(sys_clk), .rst(rst),
      .reg_page(reg_page), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .left_chan(left_chan), .right_chan(right_chan), .ramp_busy(ramp_busy));
   // 50 MHz clock
   initial forever #10 sys_clk = ~sys_clk;
   // amp connected: codes 117 and up share the deepest step, otherwise they mute
   function automatic svc_pkg::svc_chan_t exp_chan(input logic rt, input logic [7:0] v);
      return '{rt, v[7], !v[7] && v[6:0] >= 7'h75, (v[7] && v[6:0] >= 7'h75) ? 7'h75 : v[6:0]};
   endfunction : exp_chan
   function automatic int step_of(input logic [1:0] t);
      return (t == 2'h0) ? 2 : (t == 2'h1) ? 3 : 4;
   endfunction : step_of
   // left ramp watch: single-code moves, one interval apart; skipped while the amp is connected, as clamped steps hide moves
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      prev_l <= left_chan;
      if (rst || reg_wr) have_prev <= 1'b0;
      else if (left_chan.code !== prev_l.code && !left_chan.amp_conn && !prev_l.amp_conn && tcode != 2'h3) begin
         `CHK(left_chan.code == prev_l.code + 7'h01 || left_chan.code + 7'h01 == prev_l.code, 1'b1)
         if (have_prev) `CHK(cyc - last_chg, step_of(tcode))
         last_chg <= cyc;
         have_prev <= 1'b1;
      end
   end
   task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_page <= pg;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic pg, input logic [7:0] a, input logic [7:0] e, input logic hit);
      @(posedge sys_clk);
      reg_page <= pg;
      reg_addr <= a;
      @(negedge sys_clk);
      `CHK({reg_hit, reg_rdata}, {hit, e})
   endtask : rd
   // program all four registers, read back, then wait for both ramps to land
   task automatic run(input logic [7:0] t, input logic [7:0] rt, input logic [7:0] lv, input logic [7:0] rv);
      int n;
      tcode = t[1:0];
      wr(1'h0, 8'h3f, t);
      wr(1'h1, 8'h23, rt);
      wr(1'h1, 8'h26, lv);
      wr(1'h1, 8'h27, rv);
      @(negedge sys_clk);
      n = int'(lv[6:0]) - int'(cur_l);
      if (t[1:0] != 2'h3 && (n > 3 || n < -3)) `CHK(ramp_busy, 1'b1)
      cur_l = lv[6:0];
      rd(1'h0, 8'h3f, t, 1'b1);
      rd(1'h1, 8'h23, rt, 1'b1);
      rd(1'h1, 8'h26, lv, 1'b1);
      rd(1'h1, 8'h27, rv, 1'b1);
      n = 0;
      while (ramp_busy !== 1'b0 && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK({ramp_busy, left_chan}, {1'b0, exp_chan(rt[6], lv)})
      `CHK(right_chan, exp_chan(rt[2], rv))
   endtask : run
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   // watchdog well past the longest expected run
   initial begin
      #1000000;
      failures++;
      give_verdict();
   end
   // reset values, refusal, corner codes, random traffic, mid-run reset
   initial begin
      void'($urandom(32'h905d));
      repeat (8) @(posedge sys_clk);
      `CHK({ramp_busy, left_chan}, 11'h000)
      rst <= 1'b0;
      repeat (3) @(negedge sys_clk);
      `CHK(left_chan, exp_chan(1'b0, 8'h7f))
      rd(1'h1, 8'h23, 8'h00, 1'b1);
      rd(1'h1, 8'h27, 8'h7f, 1'b1);
      rd(1'h0, 8'h3f, 8'h00, 1'b1);
      wr(1'h0, 8'h26, 8'h55);
      rd(1'h0, 8'h26, 8'h00, 1'b0);
      rd(1'h1, 8'h26, 8'h7f, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 10; i++) run(8'(i % 4), i[0] ? 8'h44 : 8'h00, {i[0], corner[i / 2]}, {~i[0], corner[i / 2]});
      $display("test corners done");
      for (int i = 0; i < 20; i++) run(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
      $display("test random done");
      tcode = 2'h3;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      cur_l = 7'h7f;
      repeat (3) @(negedge sys_clk);
      `CHK(left_chan, exp_chan(1'b0, 8'h7f))
      rd(1'h1, 8'h26, 8'h7f, 1'b1);
      $display("test rereset done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
